// [include/bc_walk_pkg.sv]
/*
  shared constants and carrier types for the bus-controller poll compare
  and list walker. assumes a 16-bit word-addressed shared memory.
*/
package bc_walk_pkg;
  // ==========================================================
  // widths
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 16;

  // ==========================================================
  // command block layout, word offsets from the head location
  localparam logic [15:0] CTRL_OFS  = 16'h0000;
  localparam logic [15:0] STAT1_OFS = 16'h0004;
  localparam logic [15:0] TAIL_OFS  = 16'h0008;

  // ==========================================================
  // interrupt log entry
  localparam logic [15:0] LOG_W1_OFS   = 16'h0001;
  localparam logic [15:0] LOG_R_OFS    = 16'h0002;
  localparam logic [15:0] LOG_ENTRY_SZ = 16'h0003;
  localparam int unsigned LOG_SEEN_BIT = 15;
  localparam int unsigned LOG_POLL_BIT = 3;

  // ==========================================================
  // reset values
  localparam logic [15:0] PTR_RST  = 16'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum {
    ST_IDLE, ST_FETCH, ST_WAIT_MSG, ST_LOG_W0, ST_LOG_W1, ST_LOG_R,
    ST_UPD_STAT, ST_UPD_CTRL, ST_RD_TAIL
  } walk_st_t;

  // memory request carrier
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  // whole state of the walker
  typedef struct packed {
    walk_st_t    st;
    logic [15:0] curBlk;
    logic [15:0] logPtr;
    logic [15:0] statWord;
    logic        pollHit;
    logic        logPoll;
    logic [15:0] evtBits;
    logic [15:0] ctrlWb;
    logic        lastBlk;
    logic [15:0] ctrlWord;
    mem_req_t    mem;
    logic        pollIrq;
    logic        blockReady;
    logic        busy;
  } walk_state_t;
endpackage : bc_walk_pkg

// [src/bc_poll_list_walk.sv]
/*
  poll compare of terminal status words and walk of the command block
  chain and interrupt log list in shared memory.
  assumes the protocol engine, the memory arbiter and the host setup logic
  all run on clk; a memory access completes in the cycle its grant is seen
  while the request is up, and read data is valid in that cycle.
*/
// Notes on behaviour
// - each received status word is compared bitwise against the mask
// - any bit high in both, on a word without statusErr, raises the polling interrupt when enabled
// - host loads first head address; fetching starts there
// - after a block, current pointer becomes the next block address
// - log pointer starts where host puts it, advances per logged block
// - next block may sit anywhere; only the stored link is followed
// - log entries are packed back to back with no gap
// - message end: update block, write control, read tail, fetch next unless lastBlock was set
// - a log entry is two writes then one read at the log pointer
// - last word of a block holds the next block's head address
// - logged polling match sets bit 3 of the logged status word
`timescale 1ns/100ps
`default_nettype none
module bc_poll_list_walk
  import bc_walk_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic [15:0]             pollMask,
  input  wire logic                    pollIrqEn,
  input  wire logic                    start,
  input  wire logic [15:0]             hostBlkAddr,
  input  wire logic                    logLoad,
  input  wire logic [15:0]             hostLogAddr,
  input  wire logic                    statusValid,
  input  wire logic                    statusErr,
  input  wire logic [15:0]             statusWord,
  input  wire logic                    msgDone,
  input  wire logic [15:0]             msgEvtBits,
  input  wire logic [15:0]             ctrlWbData,
  input  wire logic                    lastBlock,
  input  wire logic                    mem_access_grant,
  input  wire logic [15:0]             memRdata,
  output logic                         mem_access_request,
  output logic                         memWe,
  output logic [15:0]                  memAddr,
  output logic [15:0]                  memWdata,
  output logic                         pollIrq,
  output logic                         blockReady,
  output logic [15:0]                  ctrlWord,
  output logic [15:0]                  curBlkPtr,
  output logic [15:0]                  logPtr,
  output logic                         busy
);
  import bc_walk_pkg::*;

  walk_state_t s_q;
  walk_state_t s_d;
  logic        done;
  logic        match;

  // ==========================================================
  // helpers
  function automatic logic isAccess(input walk_st_t st);
    return st inside {ST_FETCH, ST_LOG_W0, ST_LOG_W1, ST_LOG_R,
                      ST_UPD_STAT, ST_UPD_CTRL, ST_RD_TAIL};
  endfunction : isAccess

  function automatic mem_req_t accessFor(input walk_state_t s);
    mem_req_t m;
    m = '0;
    m.req = isAccess(s.st);
    unique case (s.st)
      ST_FETCH:    m.addr = s.curBlk + CTRL_OFS;
      ST_LOG_W0: begin
        m.we    = 1'b1;
        m.addr  = s.logPtr;
        m.wdata = s.evtBits;
        m.wdata[LOG_SEEN_BIT] = 1'b1;
        m.wdata[LOG_POLL_BIT] = s.logPoll | s.evtBits[LOG_POLL_BIT];
      end
      ST_LOG_W1: begin
        m.we    = 1'b1;
        m.addr  = s.logPtr + LOG_W1_OFS;
        m.wdata = s.curBlk;
      end
      ST_LOG_R:    m.addr = s.logPtr + LOG_R_OFS;
      ST_UPD_STAT: begin
        m.we    = 1'b1;
        m.addr  = s.curBlk + STAT1_OFS;
        m.wdata = s.statWord;
      end
      ST_UPD_CTRL: begin
        m.we    = 1'b1;
        m.addr  = s.curBlk + CTRL_OFS;
        m.wdata = s.ctrlWb;
      end
      ST_RD_TAIL:  m.addr = s.curBlk + TAIL_OFS;
      default:     m.addr = PTR_RST;
    endcase
    return m;
  endfunction : accessFor

  assign done  = s_q.mem.req & mem_access_grant;
  assign match = statusValid & ~statusErr & (|(statusWord & pollMask));

  // ==========================================================
  // next state
  always_comb begin
    s_d            = s_q;
    s_d.pollIrq    = 1'b0;
    s_d.blockReady = 1'b0;
    if (statusValid && !statusErr) begin
      s_d.statWord = statusWord;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        // log area top chosen by host
        if (logLoad) begin
          s_d.logPtr = hostLogAddr;
        end
        if (start) begin
          s_d.curBlk = hostBlkAddr;
          s_d.st     = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (done) begin
          s_d.ctrlWord   = memRdata;
          s_d.blockReady = 1'b1;
          s_d.st         = ST_WAIT_MSG;
        end
      end
      ST_WAIT_MSG: begin
        if (msgDone) begin
          s_d.evtBits = msgEvtBits;
          s_d.ctrlWb  = ctrlWbData;
          s_d.lastBlk = lastBlock;
          s_d.logPoll = (s_q.pollHit | match) & pollIrqEn;
          s_d.pollHit = 1'b0;
          // log on an enabled poll hit or on any nonzero event bit
          if (((s_q.pollHit | match) & pollIrqEn) || (|msgEvtBits)) begin
            s_d.st = ST_LOG_W0;
          end else begin
            s_d.st = ST_UPD_STAT;
          end
        end
      end
      ST_LOG_W0:   if (done) s_d.st = ST_LOG_W1;
      ST_LOG_W1:   if (done) s_d.st = ST_LOG_R;
      ST_LOG_R: begin
        if (done) begin
          s_d.logPtr = s_q.logPtr + LOG_ENTRY_SZ;
          s_d.st     = ST_UPD_STAT;
        end
      end
      // update, control write, tail read, fetch unless last block
      ST_UPD_STAT: if (done) s_d.st = ST_UPD_CTRL;
      ST_UPD_CTRL: if (done) s_d.st = ST_RD_TAIL;
      ST_RD_TAIL: begin
        if (done) begin
          s_d.curBlk = memRdata;
          s_d.st     = s_q.lastBlk ? ST_IDLE : ST_FETCH;
        end
      end
    endcase
    // poll interrupt; a hit at message end goes into this log
    // keeping an older hit here would log it again with the next message
    if (match && pollIrqEn) begin
      s_d.pollIrq = 1'b1;
      s_d.pollHit = !(s_q.st == ST_WAIT_MSG && msgDone);
    end
    s_d.mem  = accessFor(s_d);
    s_d.busy = (s_d.st != ST_IDLE);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q          <= '0;
      s_q.st       <= ST_IDLE;
      s_q.curBlk   <= PTR_RST;
      s_q.logPtr   <= PTR_RST;
      s_q.ctrlWord <= WORD_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs, all straight from s_q
  assign mem_access_request = s_q.mem.req;
  assign memWe              = s_q.mem.we;
  assign memAddr            = s_q.mem.addr;
  assign memWdata           = s_q.mem.wdata;
  assign pollIrq            = s_q.pollIrq;
  assign blockReady         = s_q.blockReady;
  assign ctrlWord           = s_q.ctrlWord;
  assign curBlkPtr          = s_q.curBlk;
  assign logPtr             = s_q.logPtr;
  assign busy               = s_q.busy;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  poll_match_a: assert property (
    match && pollIrqEn |=> pollIrq)
    else $error("poll match did not raise interrupt");
  poll_clean_a: assert property (
    pollIrq |-> $past(statusValid && !statusErr && pollIrqEn))
    else $error("poll interrupt without a clean status word");
  poll_mask_a: assert property (
    statusValid && !statusErr && !(|(statusWord & pollMask)) |=> !pollIrq)
    else $error("poll interrupt without a masked bit");
  fetch_start_a: assert property (
    s_q.st == ST_IDLE && start |=> mem_access_request && !memWe
      && memAddr == $past(hostBlkAddr))
    else $error("first fetch not at loaded head");
  tail_follow_a: assert property (
    s_q.st == ST_RD_TAIL && done |=> curBlkPtr == $past(memRdata))
    else $error("block pointer did not take the link");
  log_adv_a: assert property (
    s_q.st == ST_LOG_R && done |=> logPtr == $past(logPtr) + LOG_ENTRY_SZ)
    else $error("log pointer did not advance by one entry");
  log_second_a: assert property (
    s_q.st == ST_LOG_W0 && done |=> memWe && memAddr == logPtr + LOG_W1_OFS)
    else $error("second log write misplaced");
  log_bit3_a: assert property (
    s_q.st == ST_LOG_W0 && s_q.logPoll |-> memWdata[LOG_POLL_BIT]
      && memWdata[LOG_SEEN_BIT])
    else $error("logged status word lacks poll bit");
  upd_order_a: assert property (
    s_q.st == ST_UPD_STAT && done |=> mem_access_request && memWe
      && memAddr == curBlkPtr + CTRL_OFS)
    else $error("control write not after status update");
  tail_order_a: assert property (
    s_q.st == ST_UPD_CTRL && done |=> mem_access_request && !memWe
      && memAddr == curBlkPtr + TAIL_OFS)
    else $error("tail read not after control write");

  log_cov_c:   cover property (s_q.st == ST_LOG_R && done);
  chain_cov_c: cover property (s_q.st == ST_RD_TAIL && done && !s_q.lastBlk);
  poll_cov_c:  cover property (pollIrq ##[1:50] s_q.st == ST_LOG_W0);
endmodule : bc_poll_list_walk
`default_nettype wire

// [dv/mem_model.sv]
/*
  shared memory model answering the walker's access requests.
  assumes a request is held until granted, one word per grant.
*/
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        mem_access_request,
  input  wire logic        memWe,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  output logic             mem_access_grant,
  output logic [15:0]      memRdata
);
  logic [15:0] mem [0:65535];
  logic [15:0] lastQ = 16'h0;
  logic [1:0]  waitQ = 2'h0;
  initial mem_access_grant = 1'b0;
  // ==========================================================
  // grant for one cycle; slow adds wait states
  always @(posedge clk) begin
    if (mem_access_grant) begin
      mem_access_grant <= 1'b0;
      if (memWe) mem[memAddr] <= memWdata;
      lastQ <= memRdata;
    end else if (mem_access_request && waitQ == 2'h0) begin
      mem_access_grant <= 1'b1;
      waitQ <= slow ? 2'h2 : 2'h0;
    end else if (mem_access_request) begin
      waitQ <= waitQ - 2'h1;
    end
  end
  // released data bus shows a changed value, not the old one
  assign memRdata = mem_access_grant ? mem[memAddr] : ~lastQ;
endmodule : mem_model
`default_nettype wire

// [dv/tb_top.sv]
/*
  bench for the poll compare and list walker: host and terminal side
  driven at the falling edge; memory answered by mem_model.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import bc_walk_pkg::*;
  logic        clk = 1'b0;
  logic        resetn, pollIrqEn, start, logLoad, statusValid, statusErr;
  logic        msgDone, lastBlock, slow, mem_access_request, memWe;
  logic        mem_access_grant, pollIrq, blockReady, busy;
  logic [15:0] pollMask, hostBlkAddr, hostLogAddr, statusWord, msgEvtBits;
  logic [15:0] ctrlWbData, memRdata, memAddr, memWdata, ctrlWord;
  logic [15:0] curBlkPtr, logPtr, expLog;
  logic [15:0] h [4];
  logic [32:0] expQ [$];
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;

  always #12.5 clk = ~clk;

  bc_poll_list_walk dut_u (.clk, .resetn, .pollMask, .pollIrqEn, .start,
    .hostBlkAddr, .logLoad, .hostLogAddr, .statusValid, .statusErr,
    .statusWord, .msgDone, .msgEvtBits, .ctrlWbData, .lastBlock,
    .mem_access_grant, .memRdata, .mem_access_request, .memWe, .memAddr,
    .memWdata, .pollIrq, .blockReady, .ctrlWord, .curBlkPtr, .logPtr,
    .busy);
  mem_model mem_u (.clk, .slow, .mem_access_request, .memWe, .memAddr,
    .memWdata, .mem_access_grant, .memRdata);

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // monitor: each completed access against the oldest note
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      errors++;
      report_and_stop();
    end
    if (mem_access_request && mem_access_grant) begin
      if (expQ.size() == 0) check({memWe, memAddr, memWdata}, 'x);
      else check({memWe, memAddr, memWe ? memWdata : 16'h0},
                 expQ.pop_front());
    end
  end

  task automatic blk(input int i, input logic [15:0] st, evt,
                     input logic en);
    logic        hit;
    logic [15:0] wb;
    int          k;
    hit = en && (st & pollMask) != 16'h0;
    wb = $urandom;
    slow = $urandom;
    for (k = 0; k < 99 && blockReady !== 1'b1; k++) @(negedge clk);
    check(blockReady, 1'b1);
    check(ctrlWord, mem_u.mem[h[i]]);
    check(curBlkPtr, h[i]);
    pollIrqEn = en;
    statusValid = 1'b1;
    statusWord = st;
    @(negedge clk);
    check(pollIrq, hit);
    statusErr = 1'b1;
    statusWord = 16'hffff;
    @(negedge clk);
    check(pollIrq, 1'b0);
    statusValid = 1'b0;
    statusErr = 1'b0;
    msgDone = 1'b1;
    msgEvtBits = evt;
    ctrlWbData = wb;
    lastBlock = (i == 2);
    if (hit || evt != 16'h0) begin
      expQ.push_back({1'b1, expLog, evt | 16'h8000 | {hit, 3'h0}});
      expQ.push_back({1'b1, expLog + LOG_W1_OFS, h[i]});
      expQ.push_back({1'b0, expLog + LOG_R_OFS, 16'h0});
      expLog = expLog + LOG_ENTRY_SZ;
    end
    expQ.push_back({1'b1, h[i] + STAT1_OFS, st});
    expQ.push_back({1'b1, h[i] + CTRL_OFS, wb});
    expQ.push_back({1'b0, h[i] + TAIL_OFS, 16'h0});
    if (i < 2) expQ.push_back({1'b0, h[i+1], 16'h0});
    @(negedge clk);
    msgDone = 1'b0;
    for (k = 0; k < 99 && expQ.size() > 0; k++) @(negedge clk);
    check(logPtr, expLog);
    if (i < 2) check(curBlkPtr, h[i+1]);
  endtask : blk

  initial begin
    {resetn, pollIrqEn, start, logLoad, statusValid, statusErr} = '0;
    {msgDone, lastBlock, slow, pollMask, hostBlkAddr} = '0;
    {hostLogAddr, statusWord, msgEvtBits, ctrlWbData} = '0;
    void'($urandom(23106));
    h[0] = $urandom & 16'h0ff0;
    h[1] = h[0] + 16'h0009;
    h[2] = 16'hc000 | ($urandom & 16'h0ff0);
    h[3] = $urandom;
    expLog = 16'h4000 | ($urandom & 16'h00ff);
    for (int i = 0; i < 3; i++) begin
      mem_u.mem[h[i]] = $urandom;
      mem_u.mem[h[i] + TAIL_OFS] = h[i+1];
    end
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    pollMask = $urandom | 16'h0400;
    logLoad = 1'b1;
    hostLogAddr = expLog;
    @(negedge clk);
    logLoad = 1'b0;
    start = 1'b1;
    hostBlkAddr = h[0];
    expQ.push_back({1'b0, h[0], 16'h0});
    @(negedge clk);
    start = 1'b0;
    check(logPtr, expLog);
    blk(0, ($urandom & ~pollMask) | 16'h0400, 16'h0, 1'b1);
    blk(1, $urandom & ~pollMask, ($urandom & 16'h7ff7) | 16'h0002, 1'b1);
    blk(2, 16'h0400, 16'h0, 1'b0);
    check(busy, 1'b0);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
